// ===== verilog/sdcal_top.v
`timescale 1ns/1ps
`include "sdcal_defines.vh"
// Overview of operation
// (RULE_01) averaging select 0..3 gives 4, 16, 64, 256 averages
// (RULE_02) accumulation select 0..3 gives 4, 16, 64, 256 cycles per accumulation
// (RULE_03) the clock source keeps sysref period under the limit for the chosen length
// (RULE_04) sysref period too long fails calibration; no valid result is reported
// (RULE_05) calibration ends within 384*19*4^(avg+acc+2) device clock cycles
// (RULE_06) longer accumulation lengthens calibration and tolerates longer periods
// (RULE_07) complete flag reads one only while enable set and sequence finished
// (RULE_08) status bits 16:0 return the computed delay setting
// (RULE_09) result bit 16 shows sample clock inversion
// (RULE_10) result bits 15:8 coarse code, bits 7:0 fine code
// (RULE_11) status register at 0x2b2 is read-only
// (RULE_12) manual delay register at 0x2b5 resets to zero
// (RULE_13) enable rising edge starts calibration; software configures first
// (RULE_14) enabled: delay set automatically; disabled: manual register drives delay
// (RULE_15) complete flag clears on disable or new start, sets after finishing
module sdcal_top (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [11:0] i_reg_addr,
    input wire [23:0] i_reg_wdata,
    input wire i_sysref,
    output reg [23:0] o_reg_rdata,
    output reg o_cal_busy,
    output reg o_cal_failed,
    output reg [16:0] o_applied_delay
);
    localparam ST_IDLE = 2'd0;
    localparam ST_RUN = 2'd1;
    localparam ST_DONE = 2'd2;
    localparam ST_FAIL = 2'd3;

    // software visible registers and the latched calibration result
    reg enable_r;
    reg [7:0] config_r;
    reg [23:0] manual_r;
    reg [16:0] result_r;
    reg done_r;

    // sequence state, counters and the accumulated phase
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [8:0] avg_cnt_r;
    reg [8:0] acc_cnt_r;
    reg [16:0] phase_sum_r;
    reg [31:0] timeout_r;

    // values decoded from the configuration
    reg [8:0] avg_target;
    reg [8:0] acc_target;
    reg [31:0] bound;
    wire [1:0] avg_sel;
    wire [1:0] acc_sel;
    wire [3:0] exp_sum;
    wire [2:0] avg_log;

    // register port decode and read mux
    reg hit_enable;
    reg hit_config;
    reg hit_status;
    reg hit_manual;
    reg [23:0] rdata_nxt;

    // phase detector outputs and the derived result
    wire det_edge;
    wire det_bad;
    wire [8:0] det_phase;
    wire start;
    wire accum_wrap;
    wire [16:0] auto_res;
    wire [16:0] mean_full;
    wire [7:0] mean_phase;

    assign avg_sel = config_r[`SDCAL_CFG_AVG_HI:`SDCAL_CFG_AVG_LO];
    assign acc_sel = config_r[`SDCAL_CFG_ACC_HI:`SDCAL_CFG_ACC_LO];
    // exponent kept four bits wide: 3 + 3 + 2 would wrap a three-bit sum
    assign exp_sum = {2'b00, avg_sel} + {2'b00, acc_sel} + 4'd2;
    assign start = i_reg_wr && hit_enable && i_reg_wdata[0]
        && !enable_r; // see RULE_13

    // one-hot address decode shared by the write and read paths
    always @* begin
        hit_enable = 1'b0;
        hit_config = 1'b0;
        hit_status = 1'b0;
        hit_manual = 1'b0;
        if (i_reg_addr == `SDCAL_OFS_ENABLE)
            hit_enable = 1'b1;
        else if (i_reg_addr == `SDCAL_OFS_CONFIG)
            hit_config = 1'b1;
        else if (i_reg_addr == `SDCAL_OFS_STATUS)
            hit_status = 1'b1;
        else if (i_reg_addr == `SDCAL_OFS_MANUAL)
            hit_manual = 1'b1;
    end

    // read data mux; unmapped offsets read as zero
    always @* begin
        rdata_nxt = 24'h000000;
        if (hit_enable)
            rdata_nxt = {23'h000000, enable_r};
        else if (hit_config)
            rdata_nxt = {16'h0000, config_r};
        else if (hit_status)
            rdata_nxt = {6'h00, done_r && enable_r, result_r}; // see RULE_07
        else if (hit_manual)
            rdata_nxt = manual_r;
    end

    sdcal_phase_det u_det (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_sysref(i_sysref),
        .i_acc_sel(acc_sel),
        .o_edge(det_edge),
        .o_period_bad(det_bad),
        .o_phase(det_phase)
    );

    // targets: 4^(sel+1); the bound grows with both selects
    always @* begin
        avg_target = 9'd4 << {avg_sel, 1'b0}; // see RULE_01
        acc_target = 9'd4 << {acc_sel, 1'b0}; // see RULE_02, RULE_06
        bound = (`SDCAL_BOUND_A * `SDCAL_BOUND_B) << {exp_sum, 1'b0}; // see RULE_05
    end

    // mean phase: shift the sum by log2 of the average count
    assign avg_log = {1'b0, avg_sel} + 3'd1;
    assign mean_full = phase_sum_r >> {avg_log, 1'b0};
    assign mean_phase = mean_full[7:0];

    // last cycle of one accumulation window
    assign accum_wrap = (acc_cnt_r + 9'd1) >= acc_target;
    // inversion when phase lies in upper half; coarse from mean, fine from residue
    assign auto_res = {mean_phase[7], 3'b000, mean_phase[6:2], 6'b000000,
        mean_phase[1:0]}; // see RULE_09, RULE_10

    // sequence control
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: if (start) state_nxt = ST_RUN;
            ST_RUN: begin
                if (start) state_nxt = ST_RUN;
                else if (!enable_r) state_nxt = ST_IDLE;
                else if (det_bad || timeout_r >= bound) state_nxt = ST_FAIL; // see RULE_04
                else if (avg_cnt_r >= avg_target) state_nxt = ST_DONE;
            end
            default: begin
                if (start) state_nxt = ST_RUN;
                else if (!enable_r) state_nxt = ST_IDLE;
            end
        endcase
    end

    // registers and measurement datapath
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            enable_r <= 1'b0;
            config_r <= `SDCAL_RST_CONFIG;
            manual_r <= `SDCAL_RST_MANUAL; // see RULE_12
            result_r <= 17'h00000;
            done_r <= 1'b0;
            state_r <= ST_IDLE;
            avg_cnt_r <= 9'h000;
            acc_cnt_r <= 9'h000;
            phase_sum_r <= 17'h00000;
            timeout_r <= 32'h00000000;
        end else begin
            state_r <= state_nxt;
            // status offset has no write path, so it stays read-only
            if (i_reg_wr) begin // see RULE_11
                if (hit_enable)
                    enable_r <= i_reg_wdata[0];
                else if (hit_config)
                    config_r <= i_reg_wdata[7:0];
                else if (hit_manual)
                    manual_r <= {7'h00, i_reg_wdata[16:0]};
            end
            if (start) begin
                done_r <= 1'b0; // see RULE_15
                avg_cnt_r <= 9'h000;
                acc_cnt_r <= 9'h000;
                phase_sum_r <= 17'h00000;
                timeout_r <= 32'h00000000;
            end else if (state_r == ST_RUN) begin
                timeout_r <= timeout_r + 32'h00000001;
                // one accumulation spans acc_target cycles, then one average taken
                if (accum_wrap) begin
                    acc_cnt_r <= 9'h000;
                    avg_cnt_r <= avg_cnt_r + 9'd1;
                    phase_sum_r <= phase_sum_r + {9'h000, det_phase[7:0]};
                end else begin
                    acc_cnt_r <= acc_cnt_r + 9'd1;
                end
            end
            if (state_r == ST_RUN && state_nxt == ST_DONE) begin
                result_r <= auto_res; // see RULE_08
                done_r <= 1'b1;
            end
            if (!enable_r) done_r <= 1'b0; // see RULE_07
        end
    end

    // read data and applied delay outputs
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_rdata <= 24'h000000;
            o_cal_busy <= 1'b0;
            o_cal_failed <= 1'b0;
            o_applied_delay <= 17'h00000;
        end else begin
            o_cal_busy <= (state_nxt == ST_RUN);
            o_cal_failed <= (state_nxt == ST_FAIL);
            // calibrated value only while enabled, manual otherwise
            if (enable_r)
                o_applied_delay <= result_r; // see RULE_14
            else
                o_applied_delay <= manual_r[16:0]; // see RULE_14
            // read data stands until the next read strobe
            if (i_reg_rd)
                o_reg_rdata <= rdata_nxt;
        end
    end
endmodule // sdcal_top

// ===== verilog/sdcal_defines.vh
`ifndef SDCAL_DEFINES_VH
`define SDCAL_DEFINES_VH
// register offsets (register port address, byte-wide device map)
`define SDCAL_OFS_ENABLE 12'h2b0
`define SDCAL_OFS_CONFIG 12'h2b1
`define SDCAL_OFS_STATUS 12'h2b2
`define SDCAL_OFS_MANUAL 12'h2b5
// reset values
`define SDCAL_RST_CONFIG 8'h05
`define SDCAL_RST_MANUAL 24'h000000
`define SDCAL_RST_STATUS 24'h000000
// field positions
`define SDCAL_CFG_AVG_HI 3
`define SDCAL_CFG_AVG_LO 2
`define SDCAL_CFG_ACC_HI 1
`define SDCAL_CFG_ACC_LO 0
`define SDCAL_STAT_DONE_BIT 17
`define SDCAL_RES_INV_BIT 16
`define SDCAL_RES_COARSE_HI 15
`define SDCAL_RES_COARSE_LO 8
`define SDCAL_RES_FINE_HI 7
`define SDCAL_RES_FINE_LO 0
// timing: bound base factors of cal_duration_bound = 384*19*4^(avg+acc+2)
`define SDCAL_BOUND_A 384
`define SDCAL_BOUND_B 19
// sysref period limits per accumulation select, device clock cycles
`define SDCAL_PER_MAX0 16'd128
`define SDCAL_PER_MAX1 16'd1664
`define SDCAL_PER_MAX2 16'd7808
`define SDCAL_PER_MAX3 16'd32384
`endif

// ===== verilog/sdcal_phase_det.v
`timescale 1ns/1ps
`include "sdcal_defines.vh"
// measures sysref period and edge phase within one accumulation window
module sdcal_phase_det (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_sysref,
    input wire [1:0] i_acc_sel,
    output reg o_edge,
    output reg o_period_bad,
    output reg [8:0] o_phase
);
    reg sysref_d_r;
    reg [15:0] per_cnt_r;
    reg seen_r;
    reg [15:0] per_max;

    // period limit for the selected accumulation length
    always @* begin
        case (i_acc_sel)
            2'd0: per_max = `SDCAL_PER_MAX0;
            2'd1: per_max = `SDCAL_PER_MAX1;
            2'd2: per_max = `SDCAL_PER_MAX2;
            default: per_max = `SDCAL_PER_MAX3;
        endcase
    end

    // rising edge of sysref marks a period boundary
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sysref_d_r <= 1'b0;
            per_cnt_r <= 16'h0000;
            seen_r <= 1'b0;
            o_edge <= 1'b0;
            o_period_bad <= 1'b0;
            o_phase <= 9'h000;
        end else begin
            sysref_d_r <= i_sysref;
            o_edge <= i_sysref && !sysref_d_r;
            if (i_sysref && !sysref_d_r) begin
                seen_r <= 1'b1;
                per_cnt_r <= 16'h0001;
                o_phase <= per_cnt_r[8:0];
            end else if (per_cnt_r != 16'hffff) begin
                per_cnt_r <= per_cnt_r + 16'h0001;
            end
            // verdict of the last period holds until the next edge, so a short
            // run between two edges still sees a period that was too long
            if (i_sysref && !sysref_d_r)
                o_period_bad <= seen_r && (per_cnt_r > per_max);
            else if (seen_r && per_cnt_r > per_max)
                o_period_bad <= 1'b1;
        end
    end
endmodule // sdcal_phase_det

// ===== tb/sdcal_sysref_src.sv
`timescale 1ns/1ps
// clock source side: one-cycle sysref pulse every i_period device clocks
module sdcal_sysref_src (
    input wire i_clk,
    input wire [15:0] i_period,
    output reg o_sysref = 1'b0
);
    reg [15:0] cnt_r = 16'h0;
    // period kept under the limit unless a test asks for a long one
    always @(posedge i_clk) begin
        cnt_r <= (cnt_r + 16'h1 >= i_period) ? 16'h0 : cnt_r + 16'h1;
        o_sysref <= (cnt_r == 16'h0);
    end
endmodule // sdcal_sysref_src

// ===== tb/sdcal_chk_sva.sv
`timescale 1ns/1ps
module sdcal_chk (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [11:0] i_reg_addr,
    input wire [23:0] i_reg_wdata,
    input wire i_sysref,
    input wire [23:0] o_reg_rdata,
    input wire o_cal_busy,
    input wire o_cal_failed,
    input wire [16:0] o_applied_delay
);
    reg en_r;
    reg [3:0] cfg_r;
    reg [16:0] man_r;
    reg [31:0] cnt_r;
    wire a_ok = i_reg_addr == 12'h2b0 || i_reg_addr == 12'h2b1;
    wire unmap = !a_ok && i_reg_addr != 12'h2b2 && i_reg_addr != 12'h2b5;
    wire rd_st = i_reg_rd && i_reg_addr == 12'h2b2;
    wire wr_en = i_reg_wr && i_reg_addr == 12'h2b0;
    wire [31:0] bound = 32'd7296 << (32'd2 * (cfg_r[3:2] + cfg_r[1:0] + 32'd2));
    // shadow of writable fields; the design's own state is not visible here
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            en_r <= 1'b0;
            cfg_r <= 4'h5;
            man_r <= 17'h0;
            cnt_r <= 32'h0;
        end else begin
            if (wr_en)
                en_r <= i_reg_wdata[0];
            if (i_reg_wr && i_reg_addr == 12'h2b1)
                cfg_r <= i_reg_wdata[3:0];
            if (i_reg_wr && i_reg_addr == 12'h2b5)
                man_r <= i_reg_wdata[16:0];
            cnt_r <= o_cal_busy ? cnt_r + 32'h1 : 32'h0;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    a_rdata_holds: assert property (!i_reg_rd && !$past(i_reg_rd) |=> $stable(o_reg_rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (i_reg_rd && unmap |=> o_reg_rdata == 24'h0)
        else $error("unmapped read not zero");
    a_status_resv: assert property (rd_st |=> o_reg_rdata[23:18] == 6'h0)
        else $error("status reserved bits set");
    a_done_needs_en: assert property (rd_st && !en_r |=> !o_reg_rdata[17])
        else $error("complete flag set while disabled");
    a_start_busy: assert property (wr_en && i_reg_wdata[0] && !en_r |-> ##[1:2] o_cal_busy)
        else $error("enable rise did not start calibration");
    a_manual_drive: assert property (!en_r && !$past(en_r) && $stable(man_r)
        |-> o_applied_delay == man_r)
        else $error("applied delay differs from manual setting");
    a_fail_no_done: assert property (rd_st && o_cal_failed |=> !o_reg_rdata[17])
        else $error("failed calibration reports complete");
    a_cal_bound: assert property (cnt_r <= bound)
        else $error("calibration exceeded duration bound");
    c_failed: cover property (o_cal_failed);
    c_finished: cover property ($fell(o_cal_busy) && !o_cal_failed);
    c_status_on: cover property (rd_st && en_r);
endmodule // sdcal_chk

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    reg i_clk = 1'b0;
    reg i_rst_b = 1'b0;
    reg i_reg_wr = 1'b0;
    reg i_reg_rd = 1'b0;
    reg [11:0] i_reg_addr = 12'h0;
    reg [23:0] i_reg_wdata = 24'h0;
    reg [15:0] per_r = 16'd64;
    wire sysref;
    wire [23:0] o_reg_rdata;
    wire o_cal_busy;
    wire o_cal_failed;
    wire [16:0] o_applied_delay;
    integer n_errors = 0;
    integer compares = 0;
    sdcal_sysref_src sdcal_sysref_src_i (.i_clk(i_clk), .i_period(per_r), .o_sysref(sysref));
    sdcal_top sdcal_top_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .i_sysref(sysref), .o_reg_rdata(o_reg_rdata), .o_cal_busy(o_cal_busy),
        .o_cal_failed(o_cal_failed), .o_applied_delay(o_applied_delay));
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    task wr(input [11:0] a, input [23:0] v);
        begin
            @(posedge i_clk);
            i_reg_wr <= 1'b1;
            i_reg_addr <= a;
            i_reg_wdata <= v;
            @(posedge i_clk);
            i_reg_wr <= 1'b0;
        end
    endtask
    task rd(input [11:0] a, output [23:0] d);
        begin
            @(posedge i_clk);
            i_reg_rd <= 1'b1;
            i_reg_addr <= a;
            @(posedge i_clk);
            i_reg_rd <= 1'b0;
            @(posedge i_clk);
            #1 d = o_reg_rdata;
        end
    endtask
    task chk(input [8*12:1] nm, input [23:0] e, input [23:0] g);
        begin
            compares = compares + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task t_regs;
        reg [23:0] d;
        begin
            rd(12'h2b1, d);
            chk("config", 24'h000005, d);
            rd(12'h2b5, d);
            chk("manual_rst", 24'h0, d);
            rd(12'h3ff, d);
            chk("unmapped", 24'h0, d);
            wr(12'h2b5, 24'hf1bcde);
            rd(12'h2b5, d);
            chk("manual_rw", 24'h01bcde, d);
            wr(12'h2b2, 24'hffffff);
            rd(12'h2b2, d);
            chk("status_ro", 24'h0, d);
            $display("test regs done");
        end
    endtask
    // long sysref period must fail; a short one must finish and apply
    task t_cal(input [15:0] per, input [1:0] acc, input bad);
        reg [23:0] d;
        integer k;
        begin
            // config first, so the period verdict is taken against the new limit
            wr(12'h2b1, {22'h0, acc});
            per_r <= per;
            // let the source settle into the new period before starting
            repeat (3 * per) @(posedge i_clk);
            wr(12'h2b0, 24'h1);
            #1 chk("busy", 24'h1, {23'h0, o_cal_busy});
            for (k = 0; k < 60000 && o_cal_busy !== 1'b0; k = k + 1)
                @(negedge i_clk);
            chk("ended", 24'h0, {23'h0, o_cal_busy});
            chk("failed", {23'h0, bad}, {23'h0, o_cal_failed});
            rd(12'h2b2, d);
            chk("done", {23'h0, !bad}, {23'h0, d[17]});
            if (!bad)
                chk("applied", {7'h0, d[16:0]}, {7'h0, o_applied_delay});
            wr(12'h2b0, 24'h0);
            rd(12'h2b2, d);
            chk("done_off", 24'h0, {23'h0, d[17]});
            chk("manual", 24'h01bcde, {7'h0, o_applied_delay});
            $display("test cal done");
        end
    endtask
    task wrap_up;
        begin
            $display("compares %0d n_errors %0d", compares, n_errors);
            if (n_errors == 0 && compares > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    // hang guard sized above the longest calibration wait
    initial begin
        repeat (80000) @(posedge i_clk);
        n_errors = n_errors + 1;
        wrap_up;
    end
    initial begin
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        t_regs;
        t_cal(16'd200, 2'd0, 1'b1);
        t_cal(16'd64, 2'd0, 1'b0);
        t_cal(16'd200, 2'd1, 1'b0);
        wrap_up;
    end
endmodule // testbench
bind sdcal_top sdcal_chk sdcal_chk_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_sysref(i_sysref), .o_reg_rdata(o_reg_rdata), .o_cal_busy(o_cal_busy),
    .o_cal_failed(o_cal_failed), .o_applied_delay(o_applied_delay));
